// >>> hw/sfh_top.sv
// fault handler control: configuration, priorities, handler state, status
// Behaviour
// [RL1] stack alignment bit set: entry aligns stack pointer to 8 bytes, else 4
// [RL2] stack alignment bit resets to one and is writable here
// [RL3] precise fault at priority -1/-2 locks up unless ignore bit set
// [RL4] divide trap enable gates trapping of division by zero
// [RL5] trap enable gates faults on misaligned word and halfword accesses
// [RL6] misaligned multiple and exclusive accesses always fault
// [RL7] unprivileged trigger bit allows unprivileged trigger register access
// [RL8] thread entry with active exceptions faults unless entry bit set
// [RL9] handlers 4 to 15 own 8-bit priority bytes, four per register
// [RL10] priority bytes of handlers 7 and 13 are reserved
// [RL11] control_state bits 18,17,16 enable usage, bus, protection faults
// [RL12] pending bits 15..12 set on occurrence, clear on activation
// [RL13] active bits read one while exception current or nested
// [RL14] hardware and software writes both update pending and active state
// [RL15] software updates control_state by read-modify-write
// [RL16] fault status: usage 31..16, bus 15..8, protection 7..0; here only the protection byte exists, usage and bus read zero
// [RL17] fault status bits accumulate and clear only on written one
// [RL18] fault status and priority registers accept byte, halfword, word
// [RL19] address valid flag is one only while captured address is valid
// [RL20] protection fault in lazy float preservation sets its flag
// [RL21] derived faults in entry stacking and return unstacking set flags
// [RL22] data violation flag reads zero until a data violation occurs
// [RL23] data violation captures the faulting data address
// [RL24] instruction violation sets its flag only when instruction issued
// [RL25] a hardware set wins over a same-cycle software clear
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module sfh_top
   import sfh_pkg::*;
(
   input wire logic MCLK_IN,
   input wire logic SRST_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [3:0] PSTRB_IN,
   input wire sfh_mem_evt_s MEM_EVT_IN,
   input wire sfh_exc_evt_s EXC_EVT_IN,
   input wire sfh_core_req_s CORE_REQ_IN,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   output logic [31:0] PRDATA_OUT,
   output logic [31:0] SP_ALIGNED_OUT,
   output logic SP_ADJUSTED_OUT,
   output logic LOCKUP_OUT,
   output logic FAULT_IGNORED_OUT,
   output logic DIV_TRAP_OUT,
   output logic MISALIGN_FAULT_OUT,
   output logic TRIGGER_DENY_OUT,
   output logic THREAD_FAULT_OUT,
   output logic [2:0] FAULT_ENABLE_OUT
);

   sfh_apb_e state_ff;
   sfh_apb_e nxt_state;
   logic [31:0] config_control_ff;
   logic [31:0] priority_1_ff;
   logic [31:0] priority_2_ff;
   logic [31:0] priority_3_ff;
   logic [31:0] control_state_ff;
   logic [7:0] prot_status_ff;
   logic [31:0] prot_address_ff;
   logic [31:0] byte_mask;
   logic wr_commit;
   logic addr_hit;
   logic [31:0] rd_value;
   logic [31:0] cs_hw_set;
   logic [31:0] cs_hw_clr;
   logic [31:0] nxt_control_state;
   logic [7:0] ms_hw_set;
   logic [7:0] ms_w1c;
   logic [31:0] aligned_sp;

   // byte lanes selected by the strobes
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++) begin : g_lane
         assign byte_mask[lane*8 +: 8] = {8{PSTRB_IN[lane]}}; // [RL18]
      end
   endgenerate

   // apb handshake: no wait states, pready pulses in the access phase
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SFH_APB_IDLE: begin
            if (PSEL_IN && !PENABLE_IN) begin
               nxt_state = SFH_APB_ACK;
            end
         end
         SFH_APB_ACK: begin
            nxt_state = SFH_APB_IDLE;
         end
         default: begin
            nxt_state = SFH_APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         state_ff <= SFH_APB_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // a write lands only at the edge where pready is seen high
   assign wr_commit = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT
                      && addr_hit;

   // address decode and read mux; unmapped addresses read zero
   always_comb begin
      addr_hit = 1'b1;
      rd_value = 32'h0000_0000;
      case (PADDR_IN)
         SFH_OFF_CONFIG_CONTROL: begin
            rd_value = config_control_ff;
         end
         SFH_OFF_PRIORITY_1: begin
            rd_value = priority_1_ff;
         end
         SFH_OFF_PRIORITY_2: begin
            rd_value = priority_2_ff;
         end
         SFH_OFF_PRIORITY_3: begin
            rd_value = priority_3_ff;
         end
         SFH_OFF_CONTROL_STATE: begin
            rd_value = control_state_ff;
         end
         SFH_OFF_FAULT_STATUS: begin
            // usage and bus bytes are not implemented and read zero
            rd_value = {24'h00_0000, prot_status_ff}; // [RL16]
         end
         SFH_OFF_FAULT_ADDRESS: begin
            rd_value = prot_address_ff;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   // read data, ready and error are all flopped in the setup cycle
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         PREADY_OUT <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT <= 32'h0000_0000;
      end else begin
         PREADY_OUT <= (nxt_state == SFH_APB_ACK);
         if (state_ff == SFH_APB_IDLE && PSEL_IN && !PENABLE_IN) begin
            PSLVERR_OUT <= !addr_hit;
            PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : rd_value;
         end else begin
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
         end
      end
   end

   // configuration bits; reserved bits stay zero
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         config_control_ff <= SFH_CC_RESET;
         // stack alignment comes out of reset set [RL2]
         config_control_ff[SFH_CC_STACK_ALIGN_8] <= SFH_STACK_ALIGN_RESET;
      end else if (wr_commit && PADDR_IN == SFH_OFF_CONFIG_CONTROL) begin
         // stack alignment writable, reset value one [RL2]
         config_control_ff <= (config_control_ff
                               & ~(byte_mask & SFH_CC_WR_MASK))
                              | (PWDATA_IN & byte_mask & SFH_CC_WR_MASK);
      end
   end

   // priority bytes, lane-wise writes, reserved bytes masked out
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         priority_1_ff <= SFH_PRI_RESET;
         priority_2_ff <= SFH_PRI_RESET;
         priority_3_ff <= SFH_PRI_RESET;
      end else if (wr_commit) begin
         if (PADDR_IN == SFH_OFF_PRIORITY_1) begin // [RL9] [RL10] [RL18]
            priority_1_ff <= (priority_1_ff
                              & ~(byte_mask & SFH_PRI1_WR_MASK))
                             | (PWDATA_IN & byte_mask & SFH_PRI1_WR_MASK);
         end
         if (PADDR_IN == SFH_OFF_PRIORITY_2) begin // [RL9]
            priority_2_ff <= (priority_2_ff
                              & ~(byte_mask & SFH_PRI2_WR_MASK))
                             | (PWDATA_IN & byte_mask & SFH_PRI2_WR_MASK);
         end
         if (PADDR_IN == SFH_OFF_PRIORITY_3) begin // [RL9] [RL10]
            priority_3_ff <= (priority_3_ff
                              & ~(byte_mask & SFH_PRI3_WR_MASK))
                             | (PWDATA_IN & byte_mask & SFH_PRI3_WR_MASK);
         end
      end
   end

   // map sequencer events onto control_state bit positions
   always_comb begin
      cs_hw_set = 32'h0000_0000;
      cs_hw_clr = 32'h0000_0000;
      cs_hw_set[SFH_CS_PEND_LSB +: 4] = EXC_EVT_IN.pend_set; // [RL12]
      cs_hw_clr[SFH_CS_PEND_LSB +: 4] = EXC_EVT_IN.pend_taken; // [RL12]
      cs_hw_set[SFH_CS_SYSTEM_TICK_ACTIVE] = EXC_EVT_IN.act_set[6]; // [RL13]
      cs_hw_set[SFH_CS_DEFERRED_CALL_ACTIVE] = EXC_EVT_IN.act_set[5];
      cs_hw_set[SFH_CS_DEBUG_MONITOR_ACTIVE] = EXC_EVT_IN.act_set[4];
      cs_hw_set[SFH_CS_SUPERVISOR_CALL_ACTIVE] = EXC_EVT_IN.act_set[3];
      cs_hw_set[SFH_CS_USAGE_FAULT_ACTIVE] = EXC_EVT_IN.act_set[2];
      cs_hw_set[SFH_CS_BUS_FAULT_ACTIVE] = EXC_EVT_IN.act_set[1];
      cs_hw_set[SFH_CS_PROTECTION_FAULT_ACTIVE] = EXC_EVT_IN.act_set[0];
      cs_hw_clr[SFH_CS_SYSTEM_TICK_ACTIVE] = EXC_EVT_IN.act_clr[6]; // [RL13]
      cs_hw_clr[SFH_CS_DEFERRED_CALL_ACTIVE] = EXC_EVT_IN.act_clr[5];
      cs_hw_clr[SFH_CS_DEBUG_MONITOR_ACTIVE] = EXC_EVT_IN.act_clr[4];
      cs_hw_clr[SFH_CS_SUPERVISOR_CALL_ACTIVE] = EXC_EVT_IN.act_clr[3];
      cs_hw_clr[SFH_CS_USAGE_FAULT_ACTIVE] = EXC_EVT_IN.act_clr[2];
      cs_hw_clr[SFH_CS_BUS_FAULT_ACTIVE] = EXC_EVT_IN.act_clr[1];
      cs_hw_clr[SFH_CS_PROTECTION_FAULT_ACTIVE] = EXC_EVT_IN.act_clr[0];
   end

   // software write first, then hardware events; hardware has the last word
   // so an event in the same cycle as a software write is never lost
   always_comb begin
      nxt_control_state = control_state_ff;
      if (wr_commit && PADDR_IN == SFH_OFF_CONTROL_STATE) begin
         // whole bytes are replaced, so software must read-modify-write [RL15]
         // software sets enables, pending and active bits [RL11] [RL14]
         nxt_control_state = (control_state_ff
                              & ~(byte_mask & SFH_CS_WR_MASK))
                             | (PWDATA_IN & byte_mask & SFH_CS_WR_MASK);
      end
      // exception events set and clear on top of it [RL14] [RL25]
      nxt_control_state = (nxt_control_state & ~cs_hw_clr) | cs_hw_set;
   end

   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         control_state_ff <= SFH_CS_RESET;
      end else begin
         control_state_ff <= nxt_control_state & SFH_CS_WR_MASK;
      end
   end

   // protection fault events feeding the status byte
   always_comb begin
      ms_hw_set = 8'h00;
      ms_hw_set[SFH_MS_DATA_ACCESS_VIOLATION] =
         MEM_EVT_IN.data_violation; // [RL22]
      ms_hw_set[SFH_MS_ADDRESS_VALID] = MEM_EVT_IN.data_violation; // [RL19]
      ms_hw_set[SFH_MS_INSTR_ACCESS_VIOLATION] =
         MEM_EVT_IN.instr_violation && MEM_EVT_IN.instr_issued; // [RL24]
      ms_hw_set[SFH_MS_ENTRY_STACK_ERROR] = MEM_EVT_IN.entry_stack; // [RL21]
      ms_hw_set[SFH_MS_RETURN_UNSTACK_ERROR] =
         MEM_EVT_IN.return_unstack; // [RL21]
      ms_hw_set[SFH_MS_LAZY_FP_ERROR] = MEM_EVT_IN.lazy_fp; // [RL20]
      // status lives in lane 0 only; other lanes have nothing to clear
      ms_w1c = 8'h00;
      if (wr_commit && PADDR_IN == SFH_OFF_FAULT_STATUS && PSTRB_IN[0]) begin
         ms_w1c = PWDATA_IN[7:0]; // [RL18]
      end
   end

   // sticky status: bits accumulate, written ones clear, set beats clear
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         prot_status_ff <= SFH_MS_RESET;
      end else begin
         // events accumulate, set beats clear [RL17] [RL25]
         prot_status_ff <= (prot_status_ff & ~ms_w1c) | ms_hw_set;
      end
   end

   // faulting data address; read-only to software
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         prot_address_ff <= SFH_ADDR_RESET;
      end else if (MEM_EVT_IN.data_violation) begin
         prot_address_ff <= MEM_EVT_IN.data_addr; // [RL23]
      end
   end

   // stack alignment on entry [RL1]
   assign aligned_sp = config_control_ff[SFH_CC_STACK_ALIGN_8]
                       ? (CORE_REQ_IN.stack_pointer & SFH_ALIGN8_MASK)
                       : (CORE_REQ_IN.stack_pointer & SFH_ALIGN4_MASK);

   // decisions for the core, one cycle after the request
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         SP_ALIGNED_OUT <= 32'h0000_0000;
         SP_ADJUSTED_OUT <= 1'b0;
         LOCKUP_OUT <= 1'b0;
         FAULT_IGNORED_OUT <= 1'b0;
         DIV_TRAP_OUT <= 1'b0;
         MISALIGN_FAULT_OUT <= 1'b0;
         TRIGGER_DENY_OUT <= 1'b0;
         THREAD_FAULT_OUT <= 1'b0;
      end else begin
         if (CORE_REQ_IN.entry) begin
            SP_ALIGNED_OUT <= aligned_sp; // [RL1]
         end
         SP_ADJUSTED_OUT <= CORE_REQ_IN.entry
                            && (aligned_sp != CORE_REQ_IN.stack_pointer);
         // lockup is a level the core holds; here only the verdict pulse
         LOCKUP_OUT <= CORE_REQ_IN.precise_fault // [RL3]
            && CORE_REQ_IN.neg_priority
            && !config_control_ff[SFH_CC_HIGH_PRIO_FAULT_IGNORE];
         FAULT_IGNORED_OUT <= CORE_REQ_IN.precise_fault // [RL3]
            && CORE_REQ_IN.neg_priority
            && config_control_ff[SFH_CC_HIGH_PRIO_FAULT_IGNORE];
         DIV_TRAP_OUT <= CORE_REQ_IN.divide_zero // [RL4]
            && config_control_ff[SFH_CC_DIVIDE_ZERO_TRAP_EN];
         // multiple and exclusive accesses fault whatever the trap bit [RL6]
         MISALIGN_FAULT_OUT <= CORE_REQ_IN.misaligned_multi
            || (CORE_REQ_IN.misaligned_wh // [RL5]
                && config_control_ff[SFH_CC_MISALIGNED_TRAP_EN]);
         TRIGGER_DENY_OUT <= CORE_REQ_IN.unpriv_trigger // [RL7]
            && !config_control_ff[SFH_CC_UNPRIV_TRIGGER_ALLOW];
         THREAD_FAULT_OUT <= CORE_REQ_IN.thread_return // [RL8]
            && CORE_REQ_IN.nested_active
            && !config_control_ff[SFH_CC_THREAD_ENTRY_NESTED_ALLOW];
      end
   end

   // fault enables mirrored to the exception sequencer [RL11]
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         FAULT_ENABLE_OUT <= 3'b000;
      end else begin
         FAULT_ENABLE_OUT <= {
            nxt_control_state[SFH_CS_USAGE_FAULT_ENABLE],
            nxt_control_state[SFH_CS_BUS_FAULT_ENABLE],
            nxt_control_state[SFH_CS_PROTECTION_FAULT_ENABLE]};
      end
   end

endmodule

// >>> hw/sfh_pkg.sv
// package: register map, field positions and types of the fault handler block
package sfh_pkg;

   // register byte offsets on the apb slave
   localparam logic [7:0] SFH_OFF_CONFIG_CONTROL = 8'h00;
   localparam logic [7:0] SFH_OFF_PRIORITY_1 = 8'h04;
   localparam logic [7:0] SFH_OFF_PRIORITY_2 = 8'h08;
   localparam logic [7:0] SFH_OFF_PRIORITY_3 = 8'h0c;
   localparam logic [7:0] SFH_OFF_CONTROL_STATE = 8'h10;
   localparam logic [7:0] SFH_OFF_FAULT_STATUS = 8'h14;
   localparam logic [7:0] SFH_OFF_FAULT_ADDRESS = 8'h18;

   // config_control field positions
   localparam int SFH_CC_STACK_ALIGN_8 = 9;
   localparam int SFH_CC_HIGH_PRIO_FAULT_IGNORE = 8;
   localparam int SFH_CC_DIVIDE_ZERO_TRAP_EN = 4;
   localparam int SFH_CC_MISALIGNED_TRAP_EN = 3;
   localparam int SFH_CC_UNPRIV_TRIGGER_ALLOW = 1;
   localparam int SFH_CC_THREAD_ENTRY_NESTED_ALLOW = 0;
   localparam logic [31:0] SFH_CC_WR_MASK = 32'h0000_031b;
   localparam logic SFH_STACK_ALIGN_RESET = 1'b1;
   localparam logic [31:0] SFH_CC_RESET = 32'h0000_0000;

   // priority registers: reserved bytes read zero, ignore writes
   localparam logic [31:0] SFH_PRI1_WR_MASK = 32'h00ff_ffff;
   localparam logic [31:0] SFH_PRI2_WR_MASK = 32'hffff_ffff;
   localparam logic [31:0] SFH_PRI3_WR_MASK = 32'hffff_00ff;
   localparam logic [31:0] SFH_PRI_RESET = 32'h0000_0000;

   // control_state field positions
   localparam int SFH_CS_USAGE_FAULT_ENABLE = 18;
   localparam int SFH_CS_BUS_FAULT_ENABLE = 17;
   localparam int SFH_CS_PROTECTION_FAULT_ENABLE = 16;
   localparam int SFH_CS_PEND_LSB = 12;
   localparam int SFH_CS_SYSTEM_TICK_ACTIVE = 11;
   localparam int SFH_CS_DEFERRED_CALL_ACTIVE = 10;
   localparam int SFH_CS_DEBUG_MONITOR_ACTIVE = 8;
   localparam int SFH_CS_SUPERVISOR_CALL_ACTIVE = 7;
   localparam int SFH_CS_USAGE_FAULT_ACTIVE = 3;
   localparam int SFH_CS_BUS_FAULT_ACTIVE = 1;
   localparam int SFH_CS_PROTECTION_FAULT_ACTIVE = 0;
   localparam logic [31:0] SFH_CS_WR_MASK = 32'h0007_fd8b;
   localparam logic [31:0] SFH_CS_RESET = 32'h0000_0000;

   // protection fault status byte, low byte of fault status
   localparam int SFH_MS_ADDRESS_VALID = 7;
   localparam int SFH_MS_LAZY_FP_ERROR = 5;
   localparam int SFH_MS_ENTRY_STACK_ERROR = 4;
   localparam int SFH_MS_RETURN_UNSTACK_ERROR = 3;
   localparam int SFH_MS_DATA_ACCESS_VIOLATION = 1;
   localparam int SFH_MS_INSTR_ACCESS_VIOLATION = 0;
   localparam logic [7:0] SFH_MS_RESET = 8'h00;
   localparam logic [31:0] SFH_ADDR_RESET = 32'h0000_0000;

   // stack alignment masks
   localparam logic [31:0] SFH_ALIGN8_MASK = 32'hffff_fff8;
   localparam logic [31:0] SFH_ALIGN4_MASK = 32'hffff_fffc;

   // apb slave states
   typedef enum logic [1:0] {
      SFH_APB_IDLE = 2'b01,
      SFH_APB_ACK = 2'b10
   } sfh_apb_e;

   // protection fault events reported by the memory pipeline
   typedef struct packed {
      logic data_violation;
      logic instr_violation;
      logic instr_issued;
      logic entry_stack;
      logic return_unstack;
      logic lazy_fp;
      logic [31:0] data_addr;
   } sfh_mem_evt_s;

   // exception state changes from the exception sequencer
   typedef struct packed {
      logic [3:0] pend_set;
      logic [3:0] pend_taken;
      logic [6:0] act_set;
      logic [6:0] act_clr;
   } sfh_exc_evt_s;

   // core requests that need a configuration decision
   typedef struct packed {
      logic entry;
      logic [31:0] stack_pointer;
      logic precise_fault;
      logic neg_priority;
      logic divide_zero;
      logic misaligned_wh;
      logic misaligned_multi;
      logic unpriv_trigger;
      logic thread_return;
      logic nested_active;
   } sfh_core_req_s;

endpackage

// >>> verif/sfh_top_chk.sv
// checker: port-level timing and verdict relations of the fault handler
`timescale 1ns/1ps
module sfh_top_chk
   import sfh_pkg::*;
(
   input wire logic MCLK_IN,
   input wire logic SRST_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [3:0] PSTRB_IN,
   input wire sfh_core_req_s CORE_REQ_IN,
   input wire logic PREADY_OUT,
   input wire logic PSLVERR_OUT,
   input wire logic [31:0] SP_ALIGNED_OUT,
   input wire logic SP_ADJUSTED_OUT,
   input wire logic LOCKUP_OUT,
   input wire logic FAULT_IGNORED_OUT,
   input wire logic DIV_TRAP_OUT,
   input wire logic MISALIGN_FAULT_OUT,
   input wire logic TRIGGER_DENY_OUT,
   input wire logic THREAD_FAULT_OUT,
   input wire logic [2:0] FAULT_ENABLE_OUT
);
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (SRST_IN);
   // apb phases, each used by one property
   sequence s_setup;
      PSEL_IN && !PENABLE_IN;
   endsequence
   sequence s_cs_commit;
      PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN &&
         PADDR_IN == SFH_OFF_CONTROL_STATE && PSTRB_IN[2];
   endsequence
   a_ready_after_setup: assert property (s_setup |=> PREADY_OUT)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("ready held too long");
   a_error_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
      else $error("error without ready");
   a_enable_follows_wr: assert property (s_cs_commit |=>
      FAULT_ENABLE_OUT == $past(PWDATA_IN[18:16]))
      else $error("fault enables not written");
   a_align_word_min: assert property (CORE_REQ_IN.entry ##1 1 |->
      SP_ALIGNED_OUT[1:0] == 2'h0 && SP_ALIGNED_OUT[31:3] ==
      $past(CORE_REQ_IN.stack_pointer[31:3]))
      else $error("aligned stack pointer wrong");
   a_adjust_flag_true: assert property (CORE_REQ_IN.entry |=>
      SP_ADJUSTED_OUT == (SP_ALIGNED_OUT != $past(CORE_REQ_IN.stack_pointer)))
      else $error("adjust flag disagrees");
   a_lockup_or_ignore: assert property (CORE_REQ_IN.precise_fault &&
      CORE_REQ_IN.neg_priority |=> LOCKUP_OUT ^ FAULT_IGNORED_OUT)
      else $error("lockup and ignore not exclusive");
   a_no_lockup_idle: assert property (!(CORE_REQ_IN.precise_fault &&
      CORE_REQ_IN.neg_priority) |=> !LOCKUP_OUT && !FAULT_IGNORED_OUT)
      else $error("lockup verdict without cause");
   a_multi_always_faults: assert property (
      CORE_REQ_IN.misaligned_multi |=> MISALIGN_FAULT_OUT)
      else $error("multiple access not faulted");
   a_misalign_cause: assert property (!CORE_REQ_IN.misaligned_wh &&
      !CORE_REQ_IN.misaligned_multi |=> !MISALIGN_FAULT_OUT)
      else $error("misalign fault without cause");
   a_quiet_verdicts: assert property (
      !CORE_REQ_IN.divide_zero && !CORE_REQ_IN.unpriv_trigger
      |=> !DIV_TRAP_OUT && !TRIGGER_DENY_OUT)
      else $error("trap verdict without cause");
   a_thread_needs_nest: assert property (
      !(CORE_REQ_IN.thread_return && CORE_REQ_IN.nested_active)
      |=> !THREAD_FAULT_OUT)
      else $error("thread fault without cause");
endmodule
bind sfh_top sfh_top_chk u_chk (.MCLK_IN, .SRST_IN, .PSEL_IN, .PENABLE_IN,
   .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PSTRB_IN, .CORE_REQ_IN, .PREADY_OUT,
   .PSLVERR_OUT, .SP_ALIGNED_OUT, .SP_ADJUSTED_OUT, .LOCKUP_OUT,
   .FAULT_IGNORED_OUT, .DIV_TRAP_OUT, .MISALIGN_FAULT_OUT,
   .TRIGGER_DENY_OUT, .THREAD_FAULT_OUT, .FAULT_ENABLE_OUT);

// >>> verif/sfh_top_tb.sv
// testbench: apb register and event scenarios for the fault handler
`timescale 1ns/1ps
module sfh_top_tb
   import sfh_pkg::*;
;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ev, b;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, rv, prdata, sp_al;
   logic [3:0] pstrb = '0;
   sfh_mem_evt_s mem = '0;
   sfh_exc_evt_s exc = '0;
   sfh_core_req_s core = '0;
   logic pready, pslverr, sp_adj, lock, ign, divt, mis, deny, thf;
   logic [2:0] fen;
   int n_fail = 0, tests_run = 0;
   sfh_top uut (.MCLK_IN(clk), .SRST_IN(rst), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .MEM_EVT_IN(mem),
      .EXC_EVT_IN(exc), .CORE_REQ_IN(core), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .PRDATA_OUT(prdata), .SP_ALIGNED_OUT(sp_al),
      .SP_ADJUSTED_OUT(sp_adj), .LOCKUP_OUT(lock), .FAULT_IGNORED_OUT(ign),
      .DIV_TRAP_OUT(divt), .MISALIGN_FAULT_OUT(mis),
      .TRIGGER_DENY_OUT(deny), .THREAD_FAULT_OUT(thf),
      .FAULT_ENABLE_OUT(fen));
   // 100 MHz clock
   always #5 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   // request stands until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      pen <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // read data and error taken at the very edge that sees ready
      rv = prdata;
      ev = pslverr;
      chk("apb ready", 32'h1, {31'h0, pready});
      psel <= 0;
      pen <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, '0, '0);
      chk($sformatf("reg %h", a), e, rv);
   endtask
   // one-cycle pulses on the core side ports
   task automatic req(input sfh_core_req_s q);
      @(posedge clk); core <= q; @(posedge clk); core <= '0; #1;
   endtask
   task automatic mp(input sfh_mem_evt_s m);
      @(posedge clk); mem <= m; @(posedge clk); mem <= '0;
   endtask
   task automatic xp(input sfh_exc_evt_s x);
      @(posedge clk); exc <= x; @(posedge clk); exc <= '0;
   endtask
   task automatic t_reset;
      rd(SFH_OFF_CONFIG_CONTROL, 32'h0000_0200);
      for (int i = 1; i < 7; i++) rd(8'(4 * i), 32'h0);
      apb(1'b1, 8'h1c, 32'hffff_ffff, 4'hf);
      chk("unmapped error", 32'h1, {31'h0, ev});
      $display("test reset done");
   endtask
   task automatic t_regs;
      for (int i = 1; i < 4; i++) apb(1'b1, 8'(4 * i), '1, 4'hf);
      rd(SFH_OFF_PRIORITY_1, 32'h00ff_ffff);
      rd(SFH_OFF_PRIORITY_3, 32'hffff_00ff);
      apb(1'b1, SFH_OFF_PRIORITY_2, 32'h0000_5a00, 4'b0010);
      rd(SFH_OFF_PRIORITY_2, 32'hffff_5aff);
      apb(1'b1, SFH_OFF_PRIORITY_2, 32'h1234_0000, 4'b1100);
      rd(SFH_OFF_PRIORITY_2, 32'h1234_5aff);
      apb(1'b1, SFH_OFF_CONFIG_CONTROL, '1, 4'hf);
      rd(SFH_OFF_CONFIG_CONTROL, 32'h0000_031b);
      $display("test regs done");
   endtask
   // every control bit tried in both settings
   task automatic t_cfg;
      sfh_core_req_s q;
      for (int m = 0; m < 2; m++) begin
         b = m[0];
         apb(1'b1, SFH_OFF_CONFIG_CONTROL, b ? 32'h31b : 32'h0, 4'hf);
         q = '0; q.entry = 1; q.stack_pointer = 32'h0000_1004;
         req(q);
         chk("sp", b ? 32'h1004 & SFH_ALIGN8_MASK : 32'h1004, sp_al);
         chk("sp adjusted", {31'h0, b}, {31'h0, sp_adj});
         q = '0; q.precise_fault = 1; q.neg_priority = 1; req(q);
         chk("lockup", {31'h0, !b}, {31'h0, lock});
         chk("ignored", {31'h0, b}, {31'h0, ign});
         q = '0; q.divide_zero = 1; req(q);
         chk("div trap", {31'h0, b}, {31'h0, divt});
         q = '0; q.misaligned_wh = 1; req(q);
         chk("misalign", {31'h0, b}, {31'h0, mis});
         q = '0; q.misaligned_multi = 1; req(q);
         chk("multi", 32'h1, {31'h0, mis});
         q = '0; q.unpriv_trigger = 1; req(q);
         chk("deny", {31'h0, !b}, {31'h0, deny});
         q = '0; q.thread_return = 1; q.nested_active = 1; req(q);
         chk("thread", {31'h0, !b}, {31'h0, thf});
      end
      $display("test config done");
   endtask
   task automatic t_state;
      sfh_exc_evt_s x;
      apb(1'b1, SFH_OFF_CONTROL_STATE, 32'h0007_0000, 4'b0100);
      // enables are flopped at the commit edge, look one edge later
      @(posedge clk);
      chk("enables", 32'h7, {29'h0, fen});
      x = '0; x.pend_set = 4'hf; x.act_set = 7'h7f; xp(x);
      rd(SFH_OFF_CONTROL_STATE, 32'h0007_fd8b);
      x = '0; x.pend_taken = 4'h1; x.act_clr = 7'h01; xp(x);
      rd(SFH_OFF_CONTROL_STATE, 32'h0007_ed8a);
      x = '0; x.pend_set = 4'h1; x.pend_taken = 4'h1; xp(x);
      rd(SFH_OFF_CONTROL_STATE, 32'h0007_fd8a);
      apb(1'b1, SFH_OFF_CONTROL_STATE, rv & 32'hffff_0fff, 4'hf);
      rd(SFH_OFF_CONTROL_STATE, 32'h0007_0d8a);
      apb(1'b1, SFH_OFF_CONTROL_STATE, 32'h0, 4'hf);
      @(posedge clk);
      chk("enables off", 32'h0, {29'h0, fen});
      $display("test state done");
   endtask
   task automatic t_status;
      sfh_mem_evt_s m;
      m = '0; m.data_violation = 1; m.data_addr = 32'h2000_0044; mp(m);
      rd(SFH_OFF_FAULT_STATUS, 32'h82);
      rd(SFH_OFF_FAULT_ADDRESS, 32'h2000_0044);
      m = '0; m.instr_violation = 1; mp(m);
      rd(SFH_OFF_FAULT_STATUS, 32'h82);
      m.instr_issued = 1; mp(m);
      rd(SFH_OFF_FAULT_STATUS, 32'h83);
      m = '0; m.entry_stack = 1; m.return_unstack = 1; m.lazy_fp = 1; mp(m);
      rd(SFH_OFF_FAULT_STATUS, 32'hbb);
      apb(1'b1, SFH_OFF_FAULT_STATUS, 32'h02, 4'b0001);
      rd(SFH_OFF_FAULT_STATUS, 32'hb9);
      apb(1'b1, SFH_OFF_FAULT_STATUS, '1, 4'b0011);
      rd(SFH_OFF_FAULT_STATUS, 32'h0);
      // event lands on the same edge as the clearing write commits
      fork
         apb(1'b1, SFH_OFF_FAULT_STATUS, 32'h10, 4'b0001);
         begin
            repeat (2) @(posedge clk);
            mem.entry_stack <= 1;
            @(posedge clk);
            mem.entry_stack <= 0;
         end
      join
      rd(SFH_OFF_FAULT_STATUS, 32'h10);
      $display("test status done");
   endtask
   task automatic end_of_test;
      $display("checks %0d wrong %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // watchdog well beyond the two hundred or so cycles the tests need
   initial begin
      #200000;
      n_fail++;
      end_of_test;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      t_reset;
      t_regs;
      t_cfg;
      t_state;
      t_status;
      end_of_test;
   end
endmodule
